// ===== src/dit_issue_ctrl.sv
// Dual issue decision and issue timing control for a two-way pipeline.
`timescale 1ns/1ps
`default_nettype none
module dit_issue_ctrl
  import dit_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire dit_instr_s       lead_in,
  input  wire dit_instr_s       follow_in,
  input  wire logic             lead_conflict_in,
  input  wire logic             follow_conflict_in,
  input  wire logic [3:0]       stall_cycles_in,
  input  wire logic             pipe_idle_in,
  output logic                  issue_ready_out,
  output logic                  issue_lead_out,
  output logic                  issue_pair_out,
  output dit_time_s             lead_time_out,
  output dit_time_s             follow_time_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Control register loads and stores override the group given by decode.
  function automatic dit_group_e eff_group(input dit_instr_s ins);
    unique case (ins.op)
      OP_LD_DBGSTK, OP_ST_SR: eff_group = GRP_SERIAL;
      OP_LD_CTRL, OP_ST_CTRL: eff_group = GRP_LDST;
      default:                eff_group = ins.group;
    endcase
  endfunction : eff_group

  // Base timing of each class; stall cycles are added later.
  function automatic dit_time_s op_time(input dit_op_e op);
    unique case (op)
      OP_UNAL_LD:              op_time = TM_UNAL_LD;
      OP_DBL_MUL:              op_time = TM_DBL_MUL;
      OP_LONG_MAC:             op_time = TM_LONG_MAC;
      OP_WORD_MAC:             op_time = TM_WORD_MAC;
      OP_GBR_BYTE:             op_time = TM_GBR_BYTE;
      OP_TAS:                  op_time = TM_TAS;
      OP_BR_DISP:              op_time = TM_BR_DISP;
      OP_BR_REG:               op_time = TM_BR_REG;
      OP_RETURN:               op_time = TM_RETURN;
      OP_ICINV:                op_time = TM_ICINV;
      OP_ICPREF:               op_time = TM_ICPREF;
      OP_TRAP:                 op_time = TM_TRAP;
      OP_EXC_RET:              op_time = TM_EXC_RET;
      OP_SYNC, OP_SLEEP:       op_time = TM_VARIABLE;
      OP_LDSR_REG:             op_time = TM_LDSR_REG;
      OP_LDSR_MEM:             op_time = TM_LDSR_MEM;
      OP_LD_DBGSTK:            op_time = TM_LD_DBG;
      OP_FLOAT_DIVIDE_S:               op_time = TM_FLOAT_DIVIDE_S;
      OP_FLOAT_DIVIDE_D:               op_time = TM_FLOAT_DIVIDE_D;
      OP_FLOAT_MULTIPLY_D:               op_time = TM_FLOAT_MULTIPLY_D;
      default:                 op_time = TM_SIMPLE;
    endcase
  endfunction : op_time

  // Cycles the issue slot stays closed: issue, middle sequence, least branch cycles.
  function automatic logic [CNT_W-1:0] gap_of(input dit_time_s t);
    gap_of = CNT_W'(t.issue) + CNT_W'(t.extra) + CNT_W'(t.br_min);
  endfunction : gap_of

  ////////////////////////////////////////////////////////////////////////////////
  // Pairing decision.

  dit_group_e       lead_grp;
  dit_group_e       follow_grp;
  dit_time_s        lead_time;
  dit_time_s        follow_time;
  logic             groups_pair;
  logic             same_page;
  logic             next_addr;
  logic             can_pair;
  logic             go_lead;
  logic             go_pair;
  logic [CNT_W-1:0] gap_lead;
  logic [CNT_W-1:0] gap_follow;
  logic [CNT_W-1:0] gap_total;

  assign lead_grp    = eff_group(lead_in);
  assign follow_grp  = eff_group(follow_in);
  assign lead_time   = op_time(lead_in.op);
  assign follow_time = op_time(follow_in.op);

  // Serial never pairs, move pairs with all else, the rest pair across groups.
  assign groups_pair = (lead_grp != GRP_SERIAL) && (follow_grp != GRP_SERIAL) &&
                       ((lead_grp == GRP_MOVE) || (follow_grp == GRP_MOVE) ||
                        (lead_grp != follow_grp));
  assign next_addr   = (follow_in.addr == lead_in.addr + PAIR_STEP);
  assign same_page   = (lead_in.addr[31:PAGE_LSB] == follow_in.addr[31:PAGE_LSB]);
  assign can_pair    = lead_in.valid && follow_in.valid && groups_pair &&
                       next_addr && same_page &&
                       !lead_conflict_in && !follow_conflict_in;
  assign go_lead     = issue_ready_out && lead_in.valid;
  assign go_pair     = go_lead && can_pair;

  // The issue gap is the longer of the pair plus any stall cycles.
  assign gap_lead    = gap_of(lead_time);
  assign gap_follow  = go_pair ? gap_of(follow_time) : '0;
  assign gap_total   = ((gap_lead > gap_follow) ? gap_lead : gap_follow) +
                       CNT_W'(stall_cycles_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Issue sequencer.

  typedef enum logic [1:0] {
    ST_OPEN  = 2'b00,
    ST_COUNT = 2'b01,
    ST_DRAIN = 2'b10
  } dit_state_e;

  dit_state_e       state_ff;
  dit_state_e       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             lead_var;

  assign lead_var = !lead_time.fixed;

  // Next state: a gap of one reopens at once, longer gaps count, variable ops drain.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_OPEN: begin
        if (go_lead && lead_var) begin
          nxt_state = ST_DRAIN;
        end else if (go_lead && gap_total > CNT_W'(1)) begin
          nxt_state = ST_COUNT;
          nxt_cnt   = gap_total - CNT_W'(2);
        end
      end
      ST_COUNT: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_OPEN;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_DRAIN: begin
        if (pipe_idle_in) begin
          nxt_state = ST_OPEN;
        end
      end
      default: begin
        nxt_state = ST_OPEN;
      end
    endcase
  end

  // State and counter registers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= ST_OPEN;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic nxt_ready;

  assign nxt_ready = (nxt_state == ST_OPEN);

  // Issue pulses and the timing of what was issued, held until the next issue.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      issue_ready_out <= 1'b1;
      issue_lead_out  <= 1'b0;
      issue_pair_out  <= 1'b0;
      lead_time_out   <= '0;
      follow_time_out <= '0;
    end else begin
      issue_ready_out <= nxt_ready;
      issue_lead_out  <= go_lead;
      issue_pair_out  <= go_pair;
      if (go_lead) begin
        lead_time_out   <= lead_time;
        follow_time_out <= go_pair ? follow_time : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_serial_never_pairs;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && (lead_grp == GRP_SERIAL || follow_grp == GRP_SERIAL)) |=> !issue_pair_out;
  endproperty
  a_serial_never_pairs: assert property (p_serial_never_pairs)
    else $error("Serial group instruction was paired.");

  property p_same_group_no_pair;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && lead_grp == follow_grp && lead_grp != GRP_MOVE) |=> !issue_pair_out;
  endproperty
  a_same_group_no_pair: assert property (p_same_group_no_pair)
    else $error("Two instructions of one group were paired.");

  property p_pair_needs_valid;
    @(posedge clk_in) disable iff (!arst_n_in)
      issue_pair_out |-> $past(lead_in.valid) && $past(follow_in.valid) && issue_lead_out;
  endproperty
  a_pair_needs_valid: assert property (p_pair_needs_valid)
    else $error("Pair issued without both instructions valid.");

  property p_pair_same_page;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && !same_page) |=> !issue_pair_out;
  endproperty
  a_pair_same_page: assert property (p_pair_same_page)
    else $error("Pair crossed a page boundary.");

  property p_pair_no_conflict;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && (lead_conflict_in || follow_conflict_in)) |=> !issue_pair_out;
  endproperty
  a_pair_no_conflict: assert property (p_pair_no_conflict)
    else $error("Pair issued despite a data conflict.");

  property p_unaligned_gap;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && !go_pair && lead_in.op == OP_UNAL_LD && stall_cycles_in == 4'h0)
        |=> !issue_ready_out ##1 issue_ready_out;
  endproperty
  a_unaligned_gap: assert property (p_unaligned_gap)
    else $error("Unaligned load issue gap is not two cycles.");

  property p_trap_gap;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && lead_in.op == OP_TRAP && stall_cycles_in == 4'h0)
        |=> (!issue_ready_out) [*8] ##6 issue_ready_out;
  endproperty
  a_trap_gap: assert property (p_trap_gap)
    else $error("Software trap issue gap is not fourteen cycles.");

  property p_variable_waits;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_ff == ST_DRAIN && !pipe_idle_in) |=> !issue_ready_out;
  endproperty
  a_variable_waits: assert property (p_variable_waits)
    else $error("Variable length instruction did not wait for drain.");

  property p_float_divide_double_exec;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && lead_in.op == OP_FLOAT_DIVIDE_D) |=> lead_time_out.exec == TM_FLOAT_DIVIDE_D.exec;
  endproperty
  a_float_divide_double_exec: assert property (p_float_divide_double_exec)
    else $error("Double divide occupancy is not thirty cycles.");

  property p_stall_adds;
    @(posedge clk_in) disable iff (!arst_n_in)
      (go_lead && lead_in.op == OP_SIMPLE && !go_pair && stall_cycles_in == 4'h2)
        |=> !issue_ready_out ##1 !issue_ready_out ##1 issue_ready_out;
  endproperty
  a_stall_adds: assert property (p_stall_adds)
    else $error("Stall cycles were not added to the issue gap.");

  c_pair: cover property (@(posedge clk_in) disable iff (!arst_n_in) issue_pair_out);
  c_drain: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    state_ff == ST_DRAIN ##1 state_ff == ST_OPEN);
  c_long_gap: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    go_lead && lead_in.op == OP_ICINV);

endmodule : dit_issue_ctrl
`default_nettype wire

// ===== src/dit_pkg.sv
// Package of types and timing constants for the dual issue timing control block.
package dit_pkg;

  // Functional groups of an instruction.
  typedef enum logic [2:0] {
    GRP_ARITH  = 3'h0,
    GRP_MOVE   = 3'h1,
    GRP_BRANCH = 3'h2,
    GRP_LDST   = 3'h3,
    GRP_FLOAT  = 3'h4,
    GRP_SERIAL = 3'h5
  } dit_group_e;

  // Timing classes of an instruction, as supplied by decode.
  typedef enum logic [4:0] {
    OP_SIMPLE    = 5'h00, // Any one-cycle instruction.
    OP_UNAL_LD   = 5'h01, // Unaligned load, plain or post-increment.
    OP_DBL_MUL   = 5'h02, // Signed or unsigned double multiply, long multiply.
    OP_WORD_MUL  = 5'h03, // Signed or unsigned word multiply.
    OP_LONG_MAC  = 5'h04,
    OP_WORD_MAC  = 5'h05,
    OP_GBR_BYTE  = 5'h06, // Byte and, or, test, xor through the global base.
    OP_TAS       = 5'h07,
    OP_BR_DISP   = 5'h08, // Displacement branches, conditional or not.
    OP_BR_REG    = 5'h09, // Register-indirect branches and jumps.
    OP_RETURN    = 5'h0A,
    OP_ICINV     = 5'h0B,
    OP_ICPREF    = 5'h0C,
    OP_TRAP      = 5'h0D,
    OP_EXC_RET   = 5'h0E,
    OP_SYNC      = 5'h0F,
    OP_SLEEP     = 5'h10,
    OP_LDSR_REG  = 5'h11,
    OP_LDSR_MEM  = 5'h12,
    OP_LD_DBGSTK = 5'h13, // Load of the debug base or saved stack register.
    OP_LD_CTRL   = 5'h14, // Load of any other control register.
    OP_ST_SR     = 5'h15,
    OP_ST_CTRL   = 5'h16,
    OP_FLOAT_DIVIDE_S    = 5'h17, // Single-precision divide or square root.
    OP_FLOAT_DIVIDE_D    = 5'h18, // Double-precision divide or square root.
    OP_FLOAT_MULTIPLY_D    = 5'h19
  } dit_op_e;

  // One candidate instruction from decode.
  typedef struct packed {
    logic       valid;
    dit_group_e group;
    dit_op_e    op;
    logic [31:0] addr;
  } dit_instr_s;

  // Base timing of one instruction: issue, middle sequence, branch range, occupancy.
  typedef struct packed {
    logic [3:0] issue;
    logic [2:0] extra;
    logic [1:0] br_min;
    logic [1:0] br_max;
    logic [4:0] exec;
    logic       fixed;
  } dit_time_s;

  localparam dit_time_s TM_SIMPLE   = '{4'h1, 3'h0, 2'h0, 2'h0, 5'h01, 1'b1};
  localparam dit_time_s TM_UNAL_LD  = '{4'h2, 3'h0, 2'h0, 2'h0, 5'h02, 1'b1};
  localparam dit_time_s TM_DBL_MUL  = '{4'h1, 3'h0, 2'h0, 2'h0, 5'h02, 1'b1};
  localparam dit_time_s TM_LONG_MAC = '{4'h2, 3'h0, 2'h0, 2'h0, 5'h05, 1'b1};
  localparam dit_time_s TM_WORD_MAC = '{4'h2, 3'h0, 2'h0, 2'h0, 5'h04, 1'b1};
  localparam dit_time_s TM_GBR_BYTE = '{4'h3, 3'h0, 2'h0, 2'h0, 5'h03, 1'b1};
  localparam dit_time_s TM_TAS      = '{4'h4, 3'h0, 2'h0, 2'h0, 5'h04, 1'b1};
  localparam dit_time_s TM_BR_DISP  = '{4'h1, 3'h0, 2'h0, 2'h2, 5'h01, 1'b1};
  localparam dit_time_s TM_BR_REG   = '{4'h1, 3'h0, 2'h3, 2'h3, 5'h01, 1'b1};
  localparam dit_time_s TM_RETURN   = '{4'h1, 3'h0, 2'h0, 2'h3, 5'h01, 1'b1};
  localparam dit_time_s TM_ICINV    = '{4'h8, 3'h5, 2'h3, 2'h3, 5'h0D, 1'b1};
  localparam dit_time_s TM_ICPREF   = '{4'h5, 3'h5, 2'h3, 2'h3, 5'h0A, 1'b1};
  localparam dit_time_s TM_TRAP     = '{4'h8, 3'h5, 2'h1, 2'h1, 5'h0D, 1'b1};
  localparam dit_time_s TM_EXC_RET  = '{4'h4, 3'h0, 2'h1, 2'h1, 5'h04, 1'b1};
  localparam dit_time_s TM_VARIABLE = '{4'h1, 3'h0, 2'h0, 2'h0, 5'h00, 1'b0};
  localparam dit_time_s TM_LDSR_REG = '{4'h4, 3'h0, 2'h3, 2'h3, 5'h04, 1'b1};
  localparam dit_time_s TM_LDSR_MEM = '{4'h6, 3'h0, 2'h3, 2'h3, 5'h04, 1'b1};
  localparam dit_time_s TM_LD_DBG   = '{4'h4, 3'h0, 2'h0, 2'h0, 5'h04, 1'b1};
  localparam dit_time_s TM_FLOAT_DIVIDE_S   = '{4'h1, 3'h0, 2'h0, 2'h0, 5'h0E, 1'b1};
  localparam dit_time_s TM_FLOAT_DIVIDE_D   = '{4'h1, 3'h0, 2'h0, 2'h0, 5'h1E, 1'b1};
  localparam dit_time_s TM_FLOAT_MULTIPLY_D   = '{4'h1, 3'h0, 2'h0, 2'h0, 5'h03, 1'b1};

  // Address bits that select the minimum page of 1 Kbyte.
  localparam int unsigned PAGE_LSB  = 10;
  localparam logic [31:0] PAIR_STEP = 32'h0000_0002;
  localparam int unsigned CNT_W     = 8;

endpackage : dit_pkg

// ===== sim/tb_top.sv
// Self-checking testbench for the dual issue timing control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dit_pkg::*;

  logic       clk_in;
  logic       arst_n_in;
  dit_instr_s lead_in;
  dit_instr_s follow_in;
  logic       lead_conflict_in;
  logic       follow_conflict_in;
  logic [3:0] stall_cycles_in;
  logic       pipe_idle_in;
  logic       issue_ready_out;
  logic       issue_lead_out;
  logic       issue_pair_out;
  dit_time_s  lead_time_out;
  dit_time_s  follow_time_out;
  int         failures;
  int         total_checks;

  dit_issue_ctrl uut (
    .clk_in             (clk_in),
    .arst_n_in          (arst_n_in),
    .lead_in            (lead_in),
    .follow_in          (follow_in),
    .lead_conflict_in   (lead_conflict_in),
    .follow_conflict_in (follow_conflict_in),
    .stall_cycles_in    (stall_cycles_in),
    .pipe_idle_in       (pipe_idle_in),
    .issue_ready_out    (issue_ready_out),
    .issue_lead_out     (issue_lead_out),
    .issue_pair_out     (issue_pair_out),
    .lead_time_out      (lead_time_out),
    .follow_time_out    (follow_time_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 50 ns period.
  always #25 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Compares one flag.
  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  // Compares one timing record.
  task automatic chk_time(input string name, input dit_time_s exp, input dit_time_s got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_time

  // Compares one cycle count.
  task automatic chk_cnt(input string name, input int exp, input logic [7:0] got);
    total_checks++;
    if (got !== 8'(exp)) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  // Builds one candidate instruction.
  function automatic dit_instr_s mk(input logic v, input dit_group_e g, input dit_op_e o,
                                    input logic [31:0] a);
    mk = '{v, g, o, a};
  endfunction : mk

  ////////////////////////////////////////////////////////////////////////////////
  // Offers a candidate pair at a falling edge, checks the answer and the issue gap.
  task automatic issue(input dit_instr_s l, input dit_instr_s f, input logic lc,
                       input logic fc, input logic [3:0] st, input logic ep,
                       input dit_time_s elt, input dit_time_s eft, input int gap);
    int n;
    n = 0;
    // Let an edge pass so that no input is driven twice in one time step.
    @(negedge clk_in);
    while (issue_ready_out !== 1'b1) begin
      n++;
      if (n > 60) begin
        failures++;
        print_verdict();
      end
      @(negedge clk_in);
    end
    lead_in = l;
    follow_in = f;
    lead_conflict_in = lc;
    follow_conflict_in = fc;
    stall_cycles_in = st;
    @(negedge clk_in);
    lead_in.valid = 1'b0;
    follow_in.valid = 1'b0;
    lead_conflict_in = 1'b0;
    follow_conflict_in = 1'b0;
    stall_cycles_in = 4'h0;
    chk_bit("issue_lead", 1'b1, issue_lead_out);
    chk_bit("issue_pair", ep, issue_pair_out);
    chk_time("lead_time", elt, lead_time_out);
    chk_time("follow_time", eft, follow_time_out);
    if (gap > 0) begin
      n = 0;
      while (issue_ready_out !== 1'b1 && n < 60) begin
        n++;
        @(negedge clk_in);
      end
      if (n >= 60) begin
        failures++;
        print_verdict();
      end
      chk_cnt("ready_low_cycles", gap - 1, 8'(n));
      if (gap > 1) chk_bit("lead_pulse_end", 1'b0, issue_lead_out);
    end
  endtask : issue

  // Issues one lone instruction and checks its base timing.
  task automatic run_op(input dit_op_e o, input dit_group_e g, input dit_time_s tm,
                        input int ex, input int gap);
    issue(mk(1'b1, g, o, 32'h0000_0100), '0, 1'b0, 1'b0, 4'h0, 1'b0, tm, '0, gap);
    chk_cnt("exec_cycles", ex, 8'(lead_time_out.exec));
  endtask : run_op

  // Offers a pair of one-cycle instructions and checks whether they pair.
  task automatic pair_case(input dit_group_e gl, input dit_op_e ol, input dit_group_e gf,
                           input dit_op_e of_, input logic [31:0] al, input logic [31:0] af,
                           input logic lc, input logic fc, input logic fv, input logic ep);
    issue(mk(1'b1, gl, ol, al), mk(fv, gf, of_, af), lc, fc, 4'h0, ep, TM_SIMPLE,
          ep ? TM_SIMPLE : dit_time_s'('0), 1);
  endtask : pair_case

  // Pairing table: six follow bits per lead group, serial lead row on top.
  localparam logic [35:0] PAIR_TBL = 36'h00F5DB7DE;

  // Every group combination; serial never pairs, move pairs freely, others across groups.
  task automatic group_table();
    dit_group_e gl;
    dit_group_e gf;
    logic       ep;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 6; j++) begin
        gl = dit_group_e'(i);
        gf = dit_group_e'(j);
        ep = PAIR_TBL[i*6+j];
        pair_case(gl, OP_SIMPLE, gf, OP_SIMPLE, 32'h200, 32'h202, 1'b0, 1'b0, 1'b1, ep);
      end
    end
  endtask : group_table

  // Barrier and sleep hold issue until the pipe reports it is drained.
  task automatic variable_ops();
    int n;
    for (int k = 0; k < 2; k++) begin
      pipe_idle_in = 1'b0;
      issue(mk(1'b1, GRP_SERIAL, k ? OP_SLEEP : OP_SYNC, 32'h300), '0, 1'b0, 1'b0, 4'h0,
            1'b0, TM_VARIABLE, '0, 0);
      repeat (6) begin
        chk_bit("ready_while_busy", 1'b0, issue_ready_out);
        @(negedge clk_in);
      end
      pipe_idle_in = 1'b1;
      n = 0;
      while (issue_ready_out !== 1'b1 && n < 3) begin
        n++;
        @(negedge clk_in);
      end
      chk_bit("ready_after_idle", 1'b1, issue_ready_out);
    end
  endtask : variable_ops

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog that cuts a hung run short.
  initial begin
    #2_000_000;
    failures++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    lead_in = '0;
    follow_in = '0;
    lead_conflict_in = 1'b0;
    follow_conflict_in = 1'b0;
    stall_cycles_in = 4'h0;
    pipe_idle_in = 1'b1;
    failures = 0;
    total_checks = 0;
    repeat (20) @(negedge clk_in);
    chk_bit("reset_ready", 1'b1, issue_ready_out);
    chk_bit("reset_pulse", 1'b0, issue_lead_out);
    chk_time("reset_time", '0, lead_time_out);
    arst_n_in = 1'b1;
    run_op(OP_UNAL_LD, GRP_LDST, TM_UNAL_LD, 2, 2);
    run_op(OP_DBL_MUL, GRP_ARITH, TM_DBL_MUL, 2, 1);
    run_op(OP_WORD_MUL, GRP_ARITH, TM_SIMPLE, 1, 1);
    run_op(OP_LONG_MAC, GRP_SERIAL, TM_LONG_MAC, 5, 2);
    run_op(OP_WORD_MAC, GRP_SERIAL, TM_WORD_MAC, 4, 2);
    run_op(OP_GBR_BYTE, GRP_SERIAL, TM_GBR_BYTE, 3, 3);
    run_op(OP_TAS, GRP_SERIAL, TM_TAS, 4, 4);
    run_op(OP_BR_DISP, GRP_BRANCH, TM_BR_DISP, 1, 1);
    run_op(OP_BR_REG, GRP_BRANCH, TM_BR_REG, 1, 4);
    run_op(OP_RETURN, GRP_BRANCH, TM_RETURN, 1, 1);
    run_op(OP_ICINV, GRP_SERIAL, TM_ICINV, 13, 16);
    run_op(OP_ICPREF, GRP_SERIAL, TM_ICPREF, 10, 13);
    run_op(OP_TRAP, GRP_SERIAL, TM_TRAP, 13, 14);
    run_op(OP_EXC_RET, GRP_SERIAL, TM_EXC_RET, 4, 5);
    run_op(OP_LDSR_REG, GRP_SERIAL, TM_LDSR_REG, 4, 7);
    run_op(OP_LDSR_MEM, GRP_SERIAL, TM_LDSR_MEM, 4, 9);
    run_op(OP_LD_DBGSTK, GRP_SERIAL, TM_LD_DBG, 4, 4);
    run_op(OP_LD_CTRL, GRP_LDST, TM_SIMPLE, 1, 1);
    run_op(OP_ST_SR, GRP_SERIAL, TM_SIMPLE, 1, 1);
    run_op(OP_FLOAT_DIVIDE_S, GRP_FLOAT, TM_FLOAT_DIVIDE_S, 14, 1);
    run_op(OP_FLOAT_DIVIDE_D, GRP_FLOAT, TM_FLOAT_DIVIDE_D, 30, 1);
    run_op(OP_FLOAT_MULTIPLY_D, GRP_FLOAT, TM_FLOAT_MULTIPLY_D, 3, 1);
    run_op(OP_SIMPLE, GRP_FLOAT, TM_SIMPLE, 1, 1);
    issue(mk(1'b1, GRP_LDST, OP_UNAL_LD, 32'h100), '0, 1'b0, 1'b0, 4'h3, 1'b0,
          TM_UNAL_LD, '0, 5);
    issue(mk(1'b1, GRP_ARITH, OP_SIMPLE, 32'h100), '0, 1'b0, 1'b0, 4'h2, 1'b0,
          TM_SIMPLE, '0, 3);
    group_table();
    pair_case(GRP_ARITH, OP_SIMPLE, GRP_LDST, OP_SIMPLE, 32'h200, 32'h202,
              1'b0, 1'b0, 1'b0, 1'b0);
    pair_case(GRP_ARITH, OP_SIMPLE, GRP_LDST, OP_SIMPLE, 32'h3FE, 32'h400,
              1'b0, 1'b0, 1'b1, 1'b0);
    pair_case(GRP_ARITH, OP_SIMPLE, GRP_LDST, OP_SIMPLE, 32'h3FC, 32'h3FE,
              1'b0, 1'b0, 1'b1, 1'b1);
    pair_case(GRP_ARITH, OP_SIMPLE, GRP_LDST, OP_SIMPLE, 32'h200, 32'h202,
              1'b1, 1'b0, 1'b1, 1'b0);
    pair_case(GRP_ARITH, OP_SIMPLE, GRP_LDST, OP_SIMPLE, 32'h200, 32'h202,
              1'b0, 1'b1, 1'b1, 1'b0);
    pair_case(GRP_LDST, OP_ST_SR, GRP_ARITH, OP_SIMPLE, 32'h200, 32'h202,
              1'b0, 1'b0, 1'b1, 1'b0);
    pair_case(GRP_SERIAL, OP_ST_CTRL, GRP_ARITH, OP_SIMPLE, 32'h200, 32'h202,
              1'b0, 1'b0, 1'b1, 1'b1);
    pair_case(GRP_SERIAL, OP_ST_CTRL, GRP_LDST, OP_SIMPLE, 32'h200, 32'h202,
              1'b0, 1'b0, 1'b1, 1'b0);
    variable_ops();
    print_verdict();
  end

endmodule : tb_top
`default_nettype wire
